// file: logic/crs_defines.vh
// Register offsets, field positions, reset values and codes of the CPU register set
`ifndef CRS_DEFINES_VH
`define CRS_DEFINES_VH

// ======================================================================
// Register byte offsets
`define CRS_ADR_PC      8'h00
`define CRS_ADR_ACC     8'h04
`define CRS_ADR_TMP     8'h08
`define CRS_ADR_IDX     8'h0C
`define CRS_ADR_EXT     8'h10
`define CRS_ADR_SP      8'h14
`define CRS_ADR_PSW     8'h18
`define CRS_ADR_CMD     8'h1C
`define CRS_ADR_STAT    8'h20
`define CRS_ADR_PROBE   8'h24

// ======================================================================
// Condition flag positions within the status word
`define CRS_F_H         7
`define CRS_F_I         6
`define CRS_F_IL_HI     5
`define CRS_F_IL_LO     4
`define CRS_F_N         3
`define CRS_F_Z         2
`define CRS_F_V         1
`define CRS_F_C         0

// ======================================================================
// Reset values
`define CRS_RST_WORD    16'h0000
`define CRS_RST_PSW     16'h0030

// ======================================================================
// Operation codes
`define CRS_OP_ADD8     4'h0
`define CRS_OP_SUB8     4'h1
`define CRS_OP_ADD16    4'h2
`define CRS_OP_SUB16    4'h3
`define CRS_OP_SHL8     4'h4
`define CRS_OP_SHR8     4'h5

// ======================================================================
// Address region codes
`define CRS_RGN_IO      2'h0
`define CRS_RGN_DATA    2'h1
`define CRS_RGN_PROG    2'h2
`define CRS_RGN_NONE    2'h3

`endif

// file: logic/crs_core.v
// CPU dedicated register set, condition flags and bank pointer with a Wishbone slave
// Summary of operation
// - One 64-Kbyte space; I/O area sits at the lowest addresses.
// - Data area directly above I/O; program area at the top end.
// - Program counter is a 16-bit register holding the fetch location.
// - Accumulator is 16 bits; 8-bit operations use its low byte only.
// - Temporary accumulator is the 16-bit second operand; low byte for 8-bit.
// - Index, extra pointer and stack pointer are 16-bit registers.
// - Status word: upper byte bank pointer, lower byte condition flags.
// - Bank pointer selects the register bank address in use.
// - General registers are 8 bits, eight per bank, in data memory.
// - Usable banks limited by RAM size: 16 or 32.
// - Half-carry set on carry or borrow between bits 3 and 4.
// - Interrupt enable flag 1 permits, 0 blocks; reset clears it.
// - Accept request only above current level; level 3 admits none.
// - Negative flag follows result most significant bit.
// - Zero flag set when result is zero, else cleared.
// - Add and subtract set overflow flag on two's-complement overflow, else clear it; shifts keep it.
// - Carry flag set on carry or borrow out of bit 7 (out of bit 15 for 16-bit operations).
// - Shifts load carry with the bit shifted out.
//
// The Wishbone interface to the registers and the placing of the registers were left to the implementer.
`include "crs_defines.vh"
`default_nettype none

module crs_core
#(
   parameter [8:0]  NUM_BANKS = 9'h020,
   parameter [15:0] IO_TOP    = 16'h0080,
   parameter [15:0] DATA_TOP  = 16'h0480,
   parameter [15:0] PROG_BASE = 16'h8000,
   parameter [15:0] RAM_BASE  = 16'h0100
)
(
   input  wire        mclk,
   input  wire        reset_n,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   input  wire [1:0]  irq_req_level,
   output reg         irq_accept,
   output reg  [15:0] bank_base
);

   // ===================================================================
   // Functions

   // Byte-lane merge for 16-bit registers
   function [15:0] lane_merge;
      input [15:0] old_val;
      input [15:0] new_val;
      input [1:0]  sel;
      begin
         lane_merge[7:0]  = sel[0] ? new_val[7:0]  : old_val[7:0];
         lane_merge[15:8] = sel[1] ? new_val[15:8] : old_val[15:8];
      end
   endfunction

   // Interrupt level code to level number
   function [1:0] level_of;
      input [1:0] code;
      begin
         case (code)
            2'h0:    level_of = 2'h1;
            2'h1:    level_of = 2'h1;
            2'h2:    level_of = 2'h2;
            default: level_of = 2'h3;
         endcase
      end
   endfunction

   // ===================================================================
   // Registers

   reg [15:0] program_counter;
   reg [15:0] accumulator_reg;
   reg [15:0] temp_operand_reg;
   reg [15:0] index_modifier;
   reg [15:0] extra_memory_pointer;
   reg [15:0] stack_pointer;
   reg [15:0] program_status_word;
   reg [15:0] probe_addr_reg;
   reg [1:0]  probe_rgn_reg;
   reg [3:0]  last_op_reg;

   wire [7:0] bank_select;
   wire [7:0] condition_flags;
   wire       irq_level_hi;
   wire       irq_level_lo;

   assign bank_select     = program_status_word[15:8];
   assign condition_flags = program_status_word[7:0];
   assign irq_level_hi    = condition_flags[`CRS_F_IL_HI];
   assign irq_level_lo    = condition_flags[`CRS_F_IL_LO];

   // ===================================================================
   // Bus decode

   wire        req;
   wire        wr_do;
   wire [15:0] wd16;
   wire [1:0]  sel16;

   assign req   = wb_cyc_i & wb_stb_i;
   // Writes land on the edge the master sees ack
   assign wr_do = req & wb_we_i & wb_ack_o;
   assign wd16  = wb_dat_i[15:0];
   assign sel16 = wb_sel_i[1:0];

   wire op_go;
   assign op_go = wr_do & (wb_adr_i == `CRS_ADR_CMD) & wb_sel_i[0];

   // ===================================================================
   // Arithmetic unit

   reg  [15:0] acc_next;
   reg  [7:0]  flags_next;
   reg  [16:0] wide;
   reg  [8:0]  narrow;
   reg  [4:0]  nib;
   reg         msb_a;
   reg         msb_t;
   reg         msb_r;
   reg         is_sub;

   always @*
   begin
      acc_next   = accumulator_reg;
      flags_next = condition_flags;
      wide       = 17'h00000;
      narrow     = 9'h000;
      nib        = 5'h00;
      msb_a      = 1'b0;
      msb_t      = 1'b0;
      msb_r      = 1'b0;
      is_sub     = (wb_dat_i[3:0] == `CRS_OP_SUB8) | (wb_dat_i[3:0] == `CRS_OP_SUB16);
      case (wb_dat_i[3:0])
         `CRS_OP_ADD8, `CRS_OP_SUB8:
         begin
            narrow = is_sub
                   ? ({1'b0, accumulator_reg[7:0]} - {1'b0, temp_operand_reg[7:0]})
                   : ({1'b0, accumulator_reg[7:0]} + {1'b0, temp_operand_reg[7:0]});
            acc_next[7:0] = narrow[7:0];
            msb_a = accumulator_reg[7];
            msb_t = temp_operand_reg[7];
            msb_r = narrow[7];
            // carry or borrow out of bit 7
            flags_next[`CRS_F_C] = narrow[8];
            flags_next[`CRS_F_Z] = (narrow[7:0] == 8'h00);
         end
         `CRS_OP_ADD16, `CRS_OP_SUB16:
         begin
            wide = is_sub
                 ? ({1'b0, accumulator_reg} - {1'b0, temp_operand_reg})
                 : ({1'b0, accumulator_reg} + {1'b0, temp_operand_reg});
            acc_next = wide[15:0];
            msb_a = accumulator_reg[15];
            msb_t = temp_operand_reg[15];
            msb_r = wide[15];
            flags_next[`CRS_F_C] = wide[16];
            flags_next[`CRS_F_Z] = (wide[15:0] == 16'h0000);
         end
         `CRS_OP_SHL8:
         begin
            flags_next[`CRS_F_C] = accumulator_reg[7];
            acc_next[7:0] = {accumulator_reg[6:0], 1'b0};
            flags_next[`CRS_F_N] = accumulator_reg[6];
            flags_next[`CRS_F_Z] = (accumulator_reg[6:0] == 7'h00);
         end
         `CRS_OP_SHR8:
         begin
            flags_next[`CRS_F_C] = accumulator_reg[0];
            acc_next[7:0] = {1'b0, accumulator_reg[7:1]};
            flags_next[`CRS_F_N] = 1'b0;
            flags_next[`CRS_F_Z] = (accumulator_reg[7:1] == 7'h00);
         end
         default:
         begin
            acc_next = accumulator_reg;
         end
      endcase
      if (wb_dat_i[3:0] <= `CRS_OP_SUB16)
      begin
         // half carry between bits 3 and 4
         nib = is_sub
             ? ({1'b0, accumulator_reg[3:0]} - {1'b0, temp_operand_reg[3:0]})
             : ({1'b0, accumulator_reg[3:0]} + {1'b0, temp_operand_reg[3:0]});
         flags_next[`CRS_F_H] = nib[4];
         flags_next[`CRS_F_N] = msb_r;
         flags_next[`CRS_F_V] = is_sub ? ((msb_a != msb_t) & (msb_r != msb_a))
                                       : ((msb_a == msb_t) & (msb_r != msb_a));
      end
   end

   // ===================================================================
   // Address region classifier

   reg [1:0] rgn_next;

   always @*
   begin
      // I/O at the bottom of 64 Kbytes
      if (wd16 < IO_TOP)
         rgn_next = `CRS_RGN_IO;
      else if (wd16 < DATA_TOP)
         rgn_next = `CRS_RGN_DATA;
      else if (wd16 >= PROG_BASE)
         rgn_next = `CRS_RGN_PROG;
      else
         rgn_next = `CRS_RGN_NONE;
   end

   // ===================================================================
   // Dedicated registers

   always @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         program_counter      <= `CRS_RST_WORD;
         accumulator_reg      <= `CRS_RST_WORD;
         temp_operand_reg     <= `CRS_RST_WORD;
         index_modifier       <= `CRS_RST_WORD;
         extra_memory_pointer <= `CRS_RST_WORD;
         stack_pointer        <= `CRS_RST_WORD;
         program_status_word  <= `CRS_RST_PSW;
         probe_addr_reg       <= `CRS_RST_WORD;
         probe_rgn_reg        <= `CRS_RGN_IO;
         last_op_reg          <= 4'h0;
      end
      else if (wr_do)
      begin
         case (wb_adr_i)
            `CRS_ADR_PC:
               program_counter <= lane_merge(program_counter, wd16, sel16);
            `CRS_ADR_ACC:
               accumulator_reg <= lane_merge(accumulator_reg, wd16, sel16);
            `CRS_ADR_TMP:
               temp_operand_reg <= lane_merge(temp_operand_reg, wd16, sel16);
            `CRS_ADR_IDX:
               index_modifier <= lane_merge(index_modifier, wd16, sel16);
            `CRS_ADR_EXT:
               extra_memory_pointer <= lane_merge(extra_memory_pointer, wd16, sel16);
            `CRS_ADR_SP:
               stack_pointer <= lane_merge(stack_pointer, wd16, sel16);
            `CRS_ADR_PSW:
               program_status_word <= lane_merge(program_status_word, wd16, sel16);
            `CRS_ADR_CMD:
            begin
               if (op_go)
               begin
                  accumulator_reg          <= acc_next;
                  program_status_word[7:0] <= flags_next;
                  last_op_reg              <= wb_dat_i[3:0];
               end
            end
            `CRS_ADR_PROBE:
            begin
               // Probe needs the full word to classify
               if (sel16 == 2'h3)
               begin
                  probe_addr_reg <= wd16;
                  probe_rgn_reg  <= rgn_next;
               end
            end
            default:
            begin
               probe_rgn_reg <= probe_rgn_reg;
            end
         endcase
      end
   end

   // ===================================================================
   // Bank base and interrupt decision

   wire [8:0]  bank_mask;
   wire [7:0]  bank_idx;
   wire [1:0]  cur_level;
   wire [1:0]  req_level;

   assign bank_mask = NUM_BANKS - 9'h001;
   assign bank_idx  = bank_select & bank_mask[7:0];
   assign cur_level = level_of({irq_level_hi, irq_level_lo});
   assign req_level = level_of(irq_req_level);

   always @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         bank_base  <= RAM_BASE;
         irq_accept <= 1'b0;
      end
      else
      begin
         bank_base  <= RAM_BASE + {5'h00, bank_idx, 3'h0};
         // level 1 most urgent; level 3 never taken
         irq_accept <= condition_flags[`CRS_F_I] & (req_level != 2'h3)
                       & (req_level < cur_level);
      end
   end

   // ===================================================================
   // Wishbone answer

   reg [31:0] rd_next;

   always @*
   begin
      case (wb_adr_i)
         `CRS_ADR_PC:    rd_next = {16'h0000, program_counter};
         `CRS_ADR_ACC:   rd_next = {16'h0000, accumulator_reg};
         `CRS_ADR_TMP:   rd_next = {16'h0000, temp_operand_reg};
         `CRS_ADR_IDX:   rd_next = {16'h0000, index_modifier};
         `CRS_ADR_EXT:   rd_next = {16'h0000, extra_memory_pointer};
         `CRS_ADR_SP:    rd_next = {16'h0000, stack_pointer};
         `CRS_ADR_PSW:   rd_next = {16'h0000, program_status_word};
         `CRS_ADR_CMD:   rd_next = {28'h0000000, last_op_reg};
         `CRS_ADR_STAT:  rd_next = {bank_base, 15'h0000, irq_accept};
         `CRS_ADR_PROBE: rd_next = {14'h0000, probe_rgn_reg, probe_addr_reg};
         default:        rd_next = 32'h00000000;
      endcase
   end

   // Ack one cycle after request; unmapped reads return zero
   always @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         wb_ack_o <= req & ~wb_ack_o;
         if (req & ~wb_ack_o & ~wb_we_i)
            wb_dat_o <= rd_next;
      end
   end

endmodule

`default_nettype wire

// file: dv/crs_core_assertions.sv
// Port assertions for the CPU register set
`include "crs_defines.vh"
`default_nettype none
module crs_chk
#(
   parameter [8:0]  NUM_BANKS = 9'h020,
   parameter [15:0] IO_TOP    = 16'h0080,
   parameter [15:0] DATA_TOP  = 16'h0480,
   parameter [15:0] PROG_BASE = 16'h8000,
   parameter [15:0] RAM_BASE  = 16'h0100
)
(
   input wire logic        mclk,
   input wire logic        reset_n,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic [1:0]  irq_req_level,
   input wire logic        irq_accept,
   input wire logic [15:0] bank_base
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   function automatic logic [1:0] region(input logic [15:0] a);
      return a < IO_TOP ? `CRS_RGN_IO : a < DATA_TOP ? `CRS_RGN_DATA :
             a >= PROG_BASE ? `CRS_RGN_PROG : `CRS_RGN_NONE;
   endfunction
   sequence rd_of(logic [7:0] adr);
      wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == adr;
   endsequence
   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   // ========================================
   // Bus handshake
   ack_after_req_a: assert property (take |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without a request");
   // ========================================
   // Read data
   unmapped_zero_a: assert property (
      wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) > `CRS_ADR_PROBE |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   upper_zero_a: assert property (
      wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) < `CRS_ADR_STAT
      |-> wb_dat_o[31:16] == 16'h0)
      else $error("register read wider than 16 bits");
   probe_region_a: assert property (
      rd_of(`CRS_ADR_PROBE) |-> wb_dat_o[31:16] == {14'h0, region(wb_dat_o[15:0])})
      else $error("probe region wrong");
   stat_bank_a: assert property (
      rd_of(`CRS_ADR_STAT) ##0 $stable(bank_base) |-> wb_dat_o[31:16] == bank_base)
      else $error("status read disagrees with bank base");
   // ========================================
   // Bank base and interrupt level
   bank_range_a: assert property (
      bank_base[2:0] == 3'h0 && bank_base >= RAM_BASE
      && bank_base - RAM_BASE < {NUM_BANKS, 3'h0})
      else $error("bank base off the bank grid");
   irq_block_a: assert property (
      $past(irq_req_level) == 2'h3 |-> !irq_accept)
      else $error("lowest level request accepted");
   cover property (take && wb_we_i && wb_adr_i == `CRS_ADR_CMD);
   cover property ($rose(irq_accept));
   cover property ($changed(bank_base));
endmodule

bind crs_core crs_chk #(
   .NUM_BANKS(NUM_BANKS), .IO_TOP(IO_TOP), .DATA_TOP(DATA_TOP), .PROG_BASE(PROG_BASE),
   .RAM_BASE(RAM_BASE)
) u_chk (
   .mclk(mclk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_req_level(irq_req_level),
   .irq_accept(irq_accept), .bank_base(bank_base)
);
`default_nettype wire

// file: dv/crs_tb.sv
// Self-checking bench for the CPU register set
`include "crs_defines.vh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [8:0]  NB = 9'h020;
   localparam logic [15:0] RB = 16'h0100;
   logic        mclk          = 1'b0;
   logic        reset_n       = 1'b0;
   logic        wb_cyc_i      = 1'b0;
   logic        wb_stb_i      = 1'b0;
   logic        wb_we_i       = 1'b0;
   logic [7:0]  wb_adr_i      = 8'h00;
   logic [3:0]  wb_sel_i      = 4'h0;
   logic [31:0] wb_dat_i      = 32'h0;
   logic [1:0]  irq_req_level = 2'h3;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        irq_accept;
   logic [15:0] bank_base;
   logic [31:0] rd;
   logic [23:0] e;
   logic [15:0] be;
   int          bad_count     = 0;
   int          n_checks      = 0;
   logic [35:0] ops [9] = '{{4'h0, 16'h127F, 16'h0001}, {4'h0, 16'h34FF, 16'h0001},
      {4'h1, 16'h5600, 16'h0001}, {4'h1, 16'h0080, 16'h0001}, {4'h2, 16'h7FFF, 16'h0001},
      {4'h3, 16'h0000, 16'h0001}, {4'h4, 16'hAB81, 16'h0000}, {4'h5, 16'h0001, 16'h0000},
      {4'h7, 16'h1234, 16'h0001}};
   logic [7:0]  banks [3] = '{8'h05, 8'h1F, 8'h25};
   logic [10:0] irqs [7] = '{{8'h60, 2'h0, 1'b1}, {8'h60, 2'h1, 1'b1}, {8'h60, 2'h2, 1'b0},
      {8'h70, 2'h2, 1'b1}, {8'h70, 2'h3, 1'b0}, {8'h40, 2'h0, 1'b0}, {8'h30, 2'h0, 1'b0}};
   logic [17:0] probes [6] = '{{2'h0, 16'h007F}, {2'h1, 16'h0080}, {2'h1, 16'h047F},
      {2'h3, 16'h0480}, {2'h3, 16'h7FFF}, {2'h2, 16'h8000}};

   crs_core #(
      .NUM_BANKS(NB), .IO_TOP(16'h0080), .DATA_TOP(16'h0480), .PROG_BASE(16'h8000),
      .RAM_BASE(RB)
   ) dut (
      .mclk(mclk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_req_level(irq_req_level),
      .irq_accept(irq_accept), .bank_base(bank_base)
   );

   always #10 mclk = ~mclk;

   // ========================================
   // Bus and check tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Leading edge wait gives the idle cycle the slave needs
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                       input logic [3:0] sel);
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wb_sel_i <= sel;
      do @(posedge mclk); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      xfer(1'b1, adr, dat, 4'hF);
   endtask

   task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
      xfer(1'b0, adr, 32'h0, 4'hF);
      check(rd, exp);
   endtask

   function automatic logic [23:0] op_model(input logic [3:0] op, input logic [15:0] a,
                                            input logic [15:0] t, input logic [7:0] f);
      logic [16:0] x;
      logic [16:0] y;
      logic [16:0] s;
      logic [4:0]  hs;
      int          m;
      logic        h;
      logic        v;
      logic        c;
      if (op > 4'h5) return {a, f};
      m = op[1] ? 15 : 7;
      x = op[1] ? {1'b0, a} : {9'h000, a[7:0]};
      y = op[1] ? {1'b0, t} : {9'h000, t[7:0]};
      s = op[0] ? x - y : x + y;
      hs = op[0] ? {1'b0, x[3:0]} - {1'b0, y[3:0]} : {1'b0, x[3:0]} + {1'b0, y[3:0]};
      h = hs[4];
      v = ((x[m] ^ y[m]) == op[0]) && (s[m] != x[m]);
      c = s[m + 1];
      if (op[2])
      begin
         s = {9'h000, op[0] ? {1'b0, a[7:1]} : {a[6:0], 1'b0}};
         c = op[0] ? a[0] : a[7];
         h = f[7];
         v = f[1];
      end
      return {(m == 15) ? s[15:0] : {a[15:8], s[7:0]}, h, f[6:4], s[m],
              (m == 15) ? s[15:0] == 16'h0 : s[7:0] == 8'h00, v, c};
   endfunction

   task automatic test_done();
      if (bad_count == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial
   begin
      #100000;
      bad_count++;
      test_done();
   end

   // ========================================
   // Test sequence
   initial
   begin
      repeat (4) @(posedge mclk);
      reset_n <= 1'b1;
      for (int i = 0; i < 6; i++) rdc(8'(4 * i), 32'h0);
      rdc(`CRS_ADR_PSW, 32'h0000_0030);
      rdc(`CRS_ADR_STAT, {RB, 16'h0000});
      for (int i = 0; i < 6; i++)
      begin
         wr(8'(4 * i), 32'hFFFF_A5C0 | 32'(i));
         rdc(8'(4 * i), 32'h0000_A5C0 | 32'(i));
      end
      xfer(1'b1, `CRS_ADR_IDX, 32'h0000_3C3C, 4'h1);
      rdc(`CRS_ADR_IDX, 32'h0000_A53C);
      wr(8'h28, 32'hFFFF_FFFF);
      rdc(8'h28, 32'h0);
      // Preset H and V so shifts show they are kept
      foreach (ops[i])
      begin
         e = op_model(ops[i][35:32], ops[i][31:16], ops[i][15:0], 8'h82);
         wr(`CRS_ADR_ACC, {16'h0000, ops[i][31:16]});
         wr(`CRS_ADR_TMP, {16'h0000, ops[i][15:0]});
         wr(`CRS_ADR_PSW, 32'h0000_0082);
         wr(`CRS_ADR_CMD, {28'h0, ops[i][35:32]});
         rdc(`CRS_ADR_ACC, {16'h0000, e[23:8]});
         rdc(`CRS_ADR_PSW, {24'h0, e[7:0]});
         rdc(`CRS_ADR_CMD, {28'h0, ops[i][35:32]});
      end
      // Command without its low lane must not run
      xfer(1'b1, `CRS_ADR_CMD, 32'h0000_0002, 4'h2);
      rdc(`CRS_ADR_CMD, 32'h0000_0007);
      rdc(`CRS_ADR_ACC, 32'h0000_1234);
      foreach (banks[i])
      begin
         be = RB + (16'(banks[i] & 8'(NB - 9'h001)) << 3);
         wr(`CRS_ADR_PSW, {16'h0000, banks[i], 8'h30});
         rdc(`CRS_ADR_STAT, {be, 16'h0000});
         check({16'h0000, bank_base}, {16'h0000, be});
      end
      foreach (irqs[i])
      begin
         irq_req_level <= irqs[i][2:1];
         wr(`CRS_ADR_PSW, {24'h0, irqs[i][10:3]});
         repeat (2) @(posedge mclk);
         check({31'h0, irq_accept}, {31'h0, irqs[i][0]});
         rdc(`CRS_ADR_STAT, {RB, 15'h0, irqs[i][0]});
      end
      // Mid-run reset must clear the enable flag and restore defaults
      wr(`CRS_ADR_PSW, 32'h0000_1F40);
      wr(`CRS_ADR_ACC, 32'h0000_BEEF);
      @(posedge mclk);
      reset_n <= 1'b0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      rdc(`CRS_ADR_PSW, 32'h0000_0030);
      rdc(`CRS_ADR_ACC, 32'h0000_0000);
      rdc(`CRS_ADR_STAT, {RB, 16'h0000});
      foreach (probes[i])
      begin
         xfer(1'b1, `CRS_ADR_PROBE, {16'h0000, probes[i][15:0]}, 4'h3);
         rdc(`CRS_ADR_PROBE, {14'h0, probes[i]});
      end
      xfer(1'b1, `CRS_ADR_PROBE, 32'h0, 4'h1);
      rdc(`CRS_ADR_PROBE, {14'h0, probes[5]});
      test_done();
   end
endmodule
`default_nettype wire
